/* File: src/cmb_mailbox_top.sv */
/*
  Mailbox logic of the CAN controller: transmit, producer and consumer
  mailboxes, rank arbitration, abort and retry, internal timer and stamps.
  Assumes the protocol engine on the same clock answers tx_req with
  tx_start, then tx_done or tx_lost, and reports accepted frames on rx.
*/
`timescale 1ns/1ps
module cmb_mailbox_top
  import cmb_pkg::*;
(
  input  wire logic                                mclk,
  input  wire logic                                arst_n,
  input  wire logic                                controller_enable,
  input  wire cmb_mode_t                           mode,
  input  wire logic                                mode_wr,
  input  wire logic [MBX_W-1:0]                    mode_idx,
  input  wire logic [TYPE_W-1:0]                   mailbox_object_type,
  input  wire logic [RANK_W-1:0]                   send_rank,
  input  wire logic                                ctrl_wr,
  input  wire logic [MBX_W-1:0]                    ctrl_idx,
  input  wire cmb_mcr_t                            ctrl,
  input  wire logic                                global_transfer_wr,
  input  wire logic [NUM_MBX-1:0]                  global_transfer_bits,
  input  wire logic                                global_abort_wr,
  input  wire logic [NUM_MBX-1:0]                  global_abort_bits,
  input  wire logic                                status_rd,
  input  wire logic [MBX_W-1:0]                    status_idx,
  input  wire logic [NUM_MBX-1:0]                  interrupt_mask,
  input  wire logic                                timer_tick,
  input  wire logic                                frame_start,
  input  wire logic                                frame_end,
  input  wire logic                                tx_start,
  input  wire logic                                tx_done,
  input  wire logic                                tx_lost,
  input  wire cmb_rx_t                             rx,
  output cmb_txreq_t                               tx_req,
  output logic [NUM_MBX-1:0]                       mailbox_ready_flag,
  output logic [NUM_MBX-1:0]                       abort_done_flag,
  output logic [NUM_MBX-1:0]                       message_missed_flag,
  output logic [NUM_MBX-1:0][TIME_W-1:0]           mailbox_stamp_field,
  output logic [TIME_W-1:0]                        timer_value,
  output logic [TIME_W-1:0]                        captured_time,
  output logic [NUM_MBX-1:0]                       mailbox_irq
);

  // Reset release goes through two flops; the assertion edge stays async.
  logic rst_s1_ff;
  logic rst_n_ff;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // Per-mailbox state.
  logic [NUM_MBX-1:0][TYPE_W-1:0] type_ff, nxt_type;
  logic [NUM_MBX-1:0][RANK_W-1:0] rank_ff, nxt_rank;
  logic [NUM_MBX-1:0][DLC_W-1:0]  dlc_ff, nxt_dlc;
  logic [NUM_MBX-1:0]             rtr_ff, nxt_rtr;
  logic [NUM_MBX-1:0]             pend_ff, nxt_pend;
  logic [NUM_MBX-1:0]             trig_ff, nxt_trig;
  logic [NUM_MBX-1:0]             ready_ff, nxt_ready;
  logic [NUM_MBX-1:0]             abort_ff, nxt_abort;
  logic [NUM_MBX-1:0]             missed_ff, nxt_missed;
  logic [NUM_MBX-1:0][TIME_W-1:0] stamp_ff, nxt_stamp;
  logic [NUM_MBX-1:0]             irq_ff, nxt_irq;

  // Timer and link-side state.
  logic [TIME_W-1:0] timer_ff, nxt_timer;
  logic [TIME_W-1:0] cap_ff, nxt_cap;
  cmb_lnk_state_t    lnk_ff, nxt_lnk;
  cmb_txreq_t        req_ff, nxt_req;

  // Arbiter view.
  logic [NUM_MBX-1:0] elig;
  logic               arb_any;
  logic [MBX_W-1:0]   arb_win;

  // A mailbox competes when queued; a producer also needs the remote frame.
  always_comb
  begin
    for (int i = 0; i < NUM_MBX; i++)
    begin
      elig[i] = pend_ff[i] && (type_ff[i] == MOT_TX || type_ff[i] == MOT_CONSUMER ||
                               (type_ff[i] == MOT_PRODUCER && trig_ff[i]));
    end
  end

  cmb_arb u_arb (
    .elig (elig),
    .rank (rank_ff),
    .any  (arb_any),
    .win  (arb_win)
  );

  // The timer runs free on ticks; the capture point follows the mode bit.
  always_comb
  begin
    nxt_timer = timer_ff;
    nxt_cap   = cap_ff;
    if (timer_tick)
    begin
      nxt_timer = timer_ff + 16'h0001;
    end
    if (mode.stamp_at_frame_end ? frame_end : frame_start)
    begin
      nxt_cap = timer_ff;
    end
  end

  // Link sequencer. The request is re-chosen every cycle until the engine
  // starts the frame, so a newly queued better mailbox displaces a retry.
  always_comb
  begin
    nxt_lnk = lnk_ff;
    nxt_req = req_ff;
    unique case (lnk_ff)
      LNK_IDLE, LNK_REQ:
      begin
        if (lnk_ff == LNK_REQ && tx_start)
        begin
          nxt_lnk       = LNK_SEND;
          nxt_req.valid = 1'b0;
        end
        else if (arb_any)
        begin
          nxt_lnk        = LNK_REQ;
          nxt_req.valid  = 1'b1;
          nxt_req.per_mailbox_select_bits    = arb_win;
          nxt_req.remote = rtr_ff[arb_win] || type_ff[arb_win] == MOT_CONSUMER;
          nxt_req.dlc    = dlc_ff[arb_win];
        end
        else
        begin
          nxt_lnk       = LNK_IDLE;
          nxt_req.valid = 1'b0;
        end
      end
      LNK_SEND:
      begin
        if (tx_done || tx_lost)
        begin
          nxt_lnk = LNK_IDLE;
        end
      end
    endcase
  end

  // Mailbox next state. Order inside a cycle: configuration, commands,
  // then engine events, so a completion seen together with a command wins.
  always_comb
  begin
    logic in_flight, cmd, abt;
    in_flight  = 1'b0;
    cmd        = 1'b0;
    abt        = 1'b0;
    nxt_type   = type_ff;
    nxt_rank   = rank_ff;
    nxt_dlc    = dlc_ff;
    nxt_rtr    = rtr_ff;
    nxt_pend   = pend_ff;
    nxt_trig   = trig_ff;
    nxt_ready  = ready_ff;
    nxt_abort  = abort_ff;
    nxt_missed = missed_ff;
    nxt_stamp  = stamp_ff;
    nxt_irq    = irq_ff;
    for (int i = 0; i < NUM_MBX; i++)
    begin
      in_flight = lnk_ff == LNK_SEND && req_ff.per_mailbox_select_bits == MBX_W'(i);
      cmd = (ctrl_wr && ctrl_idx == MBX_W'(i) && ctrl.transfer_command_bit) ||
            (global_transfer_wr && global_transfer_bits[i]);
      abt = (ctrl_wr && ctrl_idx == MBX_W'(i) && ctrl.abort_request_bit) ||
            (global_abort_wr && global_abort_bits[i]);
      // Reading status clears missed; a new miss below overrides it.
      if (status_rd && status_idx == MBX_W'(i))
      begin
        nxt_missed[i] = 1'b0;
      end

      if (mode_wr && mode_idx == MBX_W'(i))
      begin
        nxt_type[i]   = mailbox_object_type;
        nxt_rank[i]   = send_rank;
        nxt_pend[i]   = 1'b0;
        nxt_trig[i]   = 1'b0;
        nxt_abort[i]  = 1'b0;
        nxt_missed[i] = 1'b0;
        nxt_ready[i]  = mailbox_object_type == MOT_TX ||
                        mailbox_object_type == MOT_PRODUCER;
      end
      else
      begin
        if (cmd && type_ff[i] != MOT_DISABLED)
        begin
          nxt_ready[i] = 1'b0;
          nxt_abort[i] = 1'b0;
          nxt_pend[i]  = type_ff[i] == MOT_TX || type_ff[i] == MOT_PRODUCER ||
                         type_ff[i] == MOT_CONSUMER;
          nxt_trig[i]  = 1'b0;
          if (ctrl_wr && ctrl_idx == MBX_W'(i))
          begin
            nxt_dlc[i] = ctrl.data_length_code;
            nxt_rtr[i] = ctrl.remote_request_bit && type_ff[i] == MOT_TX;
          end
        end
        else if (abt && pend_ff[i])
        begin
          nxt_pend[i]  = 1'b0;
          nxt_ready[i] = 1'b1;
          nxt_abort[i] = !in_flight;
        end
      end

      // Engine outcome for the frame in flight.
      if (in_flight && tx_done)
      begin
        nxt_pend[i]  = 1'b0;
        nxt_stamp[i] = mode.time_trigger_select ? TIME_RST : nxt_cap;
        if (type_ff[i] != MOT_CONSUMER)
        begin
          nxt_ready[i] = 1'b1;
        end
      end
      else if (in_flight && tx_lost && pend_ff[i] && mode.retry_disable)
      begin
        nxt_pend[i]  = 1'b0;
        nxt_ready[i] = 1'b1;
        nxt_abort[i] = 1'b1;
      end

      // Frames accepted for this mailbox by the receive side.
      if (rx.valid && rx.per_mailbox_select_bits == MBX_W'(i))
      begin
        if (type_ff[i] == MOT_PRODUCER && rx.remote)
        begin
          if (ready_ff[i])
          begin
            nxt_missed[i] = 1'b1;
          end
          else
          begin
            nxt_trig[i] = 1'b1;
          end
        end
        else if ((type_ff[i] == MOT_CONSUMER || type_ff[i] == MOT_RX) && !rx.remote)
        begin
          if (ready_ff[i])
          begin
            nxt_missed[i] = 1'b1;
          end
          else if (type_ff[i] == MOT_RX || !pend_ff[i])
          begin
            nxt_ready[i] = 1'b1;
            nxt_stamp[i] = mode.time_trigger_select ? TIME_RST : nxt_cap;
          end
        end
        else if (type_ff[i] == MOT_RX_OVW && !rx.remote)
        begin
          nxt_missed[i] = ready_ff[i];
          nxt_ready[i]  = 1'b1;
          nxt_stamp[i]  = mode.time_trigger_select ? TIME_RST : nxt_cap;
        end
      end
      nxt_irq[i] = nxt_ready[i] && interrupt_mask[i];
    end
  end

  // State registers; a disabled controller holds everything at reset values.
  always_ff @(posedge mclk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      type_ff   <= '0;
      rank_ff   <= '0;
      dlc_ff    <= '0;
      rtr_ff    <= '0;
      pend_ff   <= '0;
      trig_ff   <= '0;
      ready_ff  <= '0;
      abort_ff  <= '0;
      missed_ff <= '0;
      stamp_ff  <= '0;
      irq_ff    <= '0;
      timer_ff  <= TIME_RST;
      cap_ff    <= TIME_RST;
      lnk_ff    <= LNK_IDLE;
      req_ff    <= '0;
    end
    else if (!controller_enable)
    begin
      type_ff   <= '0;
      rank_ff   <= '0;
      dlc_ff    <= '0;
      rtr_ff    <= '0;
      pend_ff   <= '0;
      trig_ff   <= '0;
      ready_ff  <= '0;
      abort_ff  <= '0;
      missed_ff <= '0;
      stamp_ff  <= '0;
      irq_ff    <= '0;
      timer_ff  <= TIME_RST;
      cap_ff    <= TIME_RST;
      lnk_ff    <= LNK_IDLE;
      req_ff    <= '0;
    end
    else
    begin
      type_ff   <= nxt_type;
      rank_ff   <= nxt_rank;
      dlc_ff    <= nxt_dlc;
      rtr_ff    <= nxt_rtr;
      pend_ff   <= nxt_pend;
      trig_ff   <= nxt_trig;
      ready_ff  <= nxt_ready;
      abort_ff  <= nxt_abort;
      missed_ff <= nxt_missed;
      stamp_ff  <= nxt_stamp;
      irq_ff    <= nxt_irq;
      timer_ff  <= nxt_timer;
      cap_ff    <= nxt_cap;
      lnk_ff    <= nxt_lnk;
      req_ff    <= nxt_req;
    end
  end

  // Every output is a flop copy; software must not touch data while
  // a mailbox shows ready low, which this block does not police.
  assign tx_req              = req_ff;
  assign mailbox_ready_flag  = ready_ff;
  assign abort_done_flag     = abort_ff;
  assign message_missed_flag = missed_ff;
  assign mailbox_stamp_field = stamp_ff;
  assign timer_value         = timer_ff;
  assign captured_time       = cap_ff;
  assign mailbox_irq         = irq_ff;

endmodule : cmb_mailbox_top

/* File: inc/cmb_pkg.sv */
/*
  Shared constants and carrier types for the CAN mailbox block: mailbox
  object type codes, link-side state codes, reset values and the packed
  structs that carry commands and frame events.
  Assumes a controller with eight mailboxes and a 16-bit internal timer.
*/
package cmb_pkg;

  // Mailbox count and field widths.
  localparam int unsigned NUM_MBX   = 8;
  localparam int unsigned MBX_W     = 3;
  localparam int unsigned RANK_W    = 4;
  localparam int unsigned DLC_W     = 4;
  localparam int unsigned TIME_W    = 16;
  localparam int unsigned TYPE_W    = 3;

  // Mailbox object type codes.
  localparam logic [TYPE_W-1:0] MOT_DISABLED = 3'h0;
  localparam logic [TYPE_W-1:0] MOT_RX       = 3'h1;
  localparam logic [TYPE_W-1:0] MOT_RX_OVW   = 3'h2;
  localparam logic [TYPE_W-1:0] MOT_TX       = 3'h3;
  localparam logic [TYPE_W-1:0] MOT_CONSUMER = 3'h4;
  localparam logic [TYPE_W-1:0] MOT_PRODUCER = 3'h5;

  // Reset values.
  localparam logic [TIME_W-1:0] TIME_RST    = 16'h0000;
  localparam logic [RANK_W-1:0] RANK_LOWEST = 4'hf;
  localparam logic [DLC_W-1:0]  DLC_RST     = 4'h0;
  localparam logic [MBX_W-1:0]  MBX_RST     = 3'h0;

  // Link-side request sequencer, one-hot.
  typedef enum logic [2:0] {
    LNK_IDLE = 3'b001,
    LNK_REQ  = 3'b010,
    LNK_SEND = 3'b100
  } cmb_lnk_state_t;

  // Controller mode bits.
  typedef struct packed {
    logic retry_disable;
    logic time_trigger_select;
    logic stamp_at_frame_end;
  } cmb_mode_t;

  // One write to a mailbox control register.
  typedef struct packed {
    logic             transfer_command_bit;
    logic             abort_request_bit;
    logic             remote_request_bit;
    logic [DLC_W-1:0] data_length_code;
  } cmb_mcr_t;

  // A frame accepted by a mailbox on the receive side.
  typedef struct packed {
    logic             valid;
    logic [MBX_W-1:0] per_mailbox_select_bits;
    logic             remote;
  } cmb_rx_t;

  // Request handed to the protocol engine.
  typedef struct packed {
    logic             valid;
    logic [MBX_W-1:0] per_mailbox_select_bits;
    logic             remote;
    logic [DLC_W-1:0] dlc;
  } cmb_txreq_t;

endpackage : cmb_pkg

/* File: src/cmb_arb.sv */
/*
  Transmit arbiter: picks the eligible mailbox with the lowest rank value,
  the lowest mailbox number breaking ties. Purely combinational.
  Assumes ranks are stable during the cycle they are sampled.
*/
`timescale 1ns/1ps
module cmb_arb
  import cmb_pkg::*;
(
  input  wire logic [NUM_MBX-1:0]             elig,
  input  wire logic [NUM_MBX-1:0][RANK_W-1:0] rank,
  output logic                                any,
  output logic [MBX_W-1:0]                    win
);

  // Scan from the top down so that an equal rank at a lower number wins.
  always_comb
  begin
    logic [RANK_W-1:0] best;
    best = RANK_LOWEST;
    any  = 1'b0;
    win  = MBX_RST;
    for (int i = NUM_MBX - 1; i >= 0; i--)
    begin
      if (elig[i] && (!any || rank[i] <= best))
      begin
        any  = 1'b1;
        best = rank[i];
        win  = MBX_W'(i);
      end
    end
  end

endmodule : cmb_arb

/* File: dv/cmb_mailbox_sva.sv */
/*
  Assertions for cmb_mailbox_top, bound to its ports.
  Assumes controller_enable stays high while the checks run.
*/
`timescale 1ns/1ps
module cmb_mailbox_sva
  import cmb_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           arst_n,
  input wire cmb_mode_t                      mode,
  input wire logic                           mode_wr,
  input wire logic [MBX_W-1:0]               mode_idx,
  input wire logic [TYPE_W-1:0]              mailbox_object_type,
  input wire logic                           ctrl_wr,
  input wire logic [MBX_W-1:0]               ctrl_idx,
  input wire cmb_mcr_t                       ctrl,
  input wire logic [NUM_MBX-1:0]             interrupt_mask,
  input wire logic                           timer_tick,
  input wire logic                           frame_start,
  input wire logic                           frame_end,
  input wire logic                           tx_start,
  input wire logic                           tx_done,
  input wire logic                           tx_lost,
  input wire cmb_txreq_t                     tx_req,
  input wire logic [NUM_MBX-1:0]             mailbox_ready_flag,
  input wire logic [NUM_MBX-1:0]             abort_done_flag,
  input wire logic [NUM_MBX-1:0][TIME_W-1:0] mailbox_stamp_field,
  input wire logic [TIME_W-1:0]              timer_value,
  input wire logic [TIME_W-1:0]              captured_time,
  input wire logic [NUM_MBX-1:0]             mailbox_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Mailbox of the frame on the wire, so a loss or completion is traced to it.
  logic [MBX_W-1:0] fl_ff;
  logic [MBX_W-1:0] nxt_fl;
  always_comb nxt_fl = (tx_start && tx_req.valid) ? tx_req.per_mailbox_select_bits : fl_ff;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      fl_ff <= MBX_RST;
    else
      fl_ff <= nxt_fl;

  property p_irq;
    mailbox_irq == (mailbox_ready_flag & $past(interrupt_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not ready and mask");
  property p_tx_cfg;
    mode_wr && mailbox_object_type == MOT_TX |=> mailbox_ready_flag[$past(mode_idx)];
  endproperty
  a_tx_cfg: assert property (p_tx_cfg) else $error("transmit setup left ready low");
  property p_cmd;
    ctrl_wr && ctrl.transfer_command_bit && !(mode_wr && mode_idx == ctrl_idx) |=> !mailbox_ready_flag[$past(ctrl_idx)];
  endproperty
  a_cmd: assert property (p_cmd) else $error("command left ready high");
  property p_retry;
    tx_lost && !mode.retry_disable |=> !mailbox_ready_flag[fl_ff] ##[0:2] tx_req.valid;
  endproperty
  a_retry: assert property (p_retry) else $error("lost frame not retried");
  property p_noretry;
    tx_lost && mode.retry_disable |=> mailbox_ready_flag[fl_ff] && abort_done_flag[fl_ff];
  endproperty
  a_noretry: assert property (p_noretry) else $error("lost frame not aborted");
  property p_stamp;
    tx_done ##1 $rose(mailbox_ready_flag[fl_ff]) |->
      mailbox_stamp_field[fl_ff] == ($past(mode.time_trigger_select) ? TIME_RST : captured_time);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp not copied");
  property p_cap;
    (frame_start && !mode.stamp_at_frame_end) || (frame_end && mode.stamp_at_frame_end)
      |=> captured_time == $past(timer_value);
  endproperty
  a_cap: assert property (p_cap) else $error("timer not captured");
  property p_tick;
    timer_tick |=> timer_value == $past(timer_value) + 16'h0001;
  endproperty
  a_tick: assert property (p_tick) else $error("timer did not advance");

  // The main traffic cases must each occur at least once.
  c_lost: cover property (tx_lost);
  c_done: cover property (tx_done);
  c_abort: cover property ($rose(|abort_done_flag));
endmodule : cmb_mailbox_sva

bind cmb_mailbox_top cmb_mailbox_sva cmb_mailbox_sva_i (.*);

/* File: dv/cmb_engine_model.sv */
/*
  Behavioural protocol engine facing the mailbox block: takes tx_req,
  wins or loses arbitration on command, and marks frame start, and frame end only on a won frame.
  Assumes it shares mclk with the block; lose and gap come from the bench.
*/
`timescale 1ns/1ps
module cmb_engine_model
  import cmb_pkg::*;
(
  input  wire logic       mclk,
  input  wire cmb_txreq_t tx_req,
  input  wire logic       lose,
  input  wire logic [3:0] gap,
  output logic            tx_start,
  output logic            tx_done,
  output logic            tx_lost,
  output logic            frame_start,
  output logic            frame_end
);
  logic [1:0] st_ff = 2'h0;
  logic [3:0] cnt_ff = 4'h0;

  // Pulses decode from state, so they are defined from time zero.
  assign tx_start    = st_ff == 2'h1;
  assign frame_start = st_ff == 2'h2;
  assign tx_lost     = st_ff == 2'h3 && cnt_ff == 4'h3 && lose;
  assign tx_done     = st_ff == 2'h3 && cnt_ff == 4'h3 && !lose;
  assign frame_end   = tx_done;

  // A request must stand gap cycles before the engine starts it; a slow gap lets the bench abort first.
  always @(posedge mclk)
  begin
    case (st_ff)
      2'h0: if (tx_req.valid && cnt_ff >= gap) st_ff <= 2'h1;
      2'h3: if (cnt_ff == 4'h3) st_ff <= 2'h0;
      default: st_ff <= st_ff + 2'h1;
    endcase
    cnt_ff <= ((st_ff == 2'h0 && tx_req.valid) || st_ff == 2'h3) ? cnt_ff + 4'h1 : 4'h0;
  end
endmodule : cmb_engine_model

/* File: dv/cmb_mailbox_top_test.sv */
/*
  Self-checking bench for cmb_mailbox_top with the engine model.
  Assumes a 200 MHz mclk; inputs change 1 ns after the rising edge.
*/
`timescale 1ns/1ps
module cmb_mailbox_top_test;
  import cmb_pkg::*;
  logic mclk, arst_n, controller_enable, mode_wr, ctrl_wr, status_rd, timer_tick, lose;
  logic global_transfer_wr, global_abort_wr, tx_start, tx_done, tx_lost, frame_start, frame_end;
  cmb_mode_t                      mode;
  cmb_mcr_t                       ctrl;
  cmb_rx_t                        rx;
  cmb_txreq_t                     tx_req;
  logic [MBX_W-1:0]               mode_idx, ctrl_idx, status_idx;
  logic [TYPE_W-1:0]              mailbox_object_type;
  logic [RANK_W-1:0]              send_rank;
  logic [3:0]                     gap;
  logic [NUM_MBX-1:0]             global_transfer_bits, global_abort_bits, interrupt_mask;
  logic [NUM_MBX-1:0]             mailbox_ready_flag, abort_done_flag, message_missed_flag, mailbox_irq;
  logic [NUM_MBX-1:0][TIME_W-1:0] mailbox_stamp_field;
  logic [TIME_W-1:0]              timer_value, captured_time;
  logic [7:0]                     sent[$];
  int                             err_count = 0, comparisons = 0, cyc = 0;

  cmb_mailbox_top cmb_mailbox_top_i (.*);
  cmb_engine_model cmb_engine_model_i (.*);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Each started frame is logged as remote, length and mailbox; a hang ends the run.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (tx_start && tx_req.valid) sent.push_back({tx_req.remote, tx_req.dlc, tx_req.per_mailbox_select_bits});
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task step;
    @(posedge mclk);
    #1;
  endtask : step
  task chk_flags(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flags
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  // Every strobe task leads with an edge, so back-to-back calls never retouch a strobe in one step.
  task cfg(input logic [2:0] i, input logic [2:0] t, input logic [3:0] r);
    step();
    mode_wr = 1'b1;
    mode_idx = i;
    mailbox_object_type = t;
    send_rank = r;
    step();
    mode_wr = 1'b0;
  endtask : cfg
  task cmd(input logic [2:0] i, input cmb_mcr_t m);
    step();
    ctrl_wr = 1'b1;
    ctrl_idx = i;
    ctrl = m;
    step();
    ctrl_wr = 1'b0;
  endtask : cmd
  task glob(input logic abt, input logic [7:0] b);
    step();
    global_transfer_wr = !abt;
    global_abort_wr = abt;
    global_transfer_bits = b;
    global_abort_bits = b;
    step();
    global_transfer_wr = 1'b0;
    global_abort_wr = 1'b0;
  endtask : glob
  task rxf(input logic [2:0] i, input logic r);
    step();
    rx = {1'b1, i, r};
    step();
    rx.valid = 1'b0;
  endtask : rxf
  task rd(input logic [2:0] i);
    step();
    status_rd = 1'b1;
    status_idx = i;
    step();
    status_rd = 1'b0;
  endtask : rd
  task wait_rdy(input logic [7:0] m);
    for (int n = 0; n < 300 && (mailbox_ready_flag & m) !== m; n++) step();
  endtask : wait_rdy
  task wait_sent(input int k);
    for (int n = 0; n < 300 && sent.size() < k; n++) step();
  endtask : wait_sent
  task tally_and_finish;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {mode_wr, ctrl_wr, global_transfer_wr, global_abort_wr, status_rd, timer_tick, lose} = 7'h00;
    {mode_idx, ctrl_idx, status_idx, mailbox_object_type, send_rank} = 16'h0000;
    {global_transfer_bits, global_abort_bits, gap} = 20'h00000;
    mode = 3'h0;
    ctrl = 7'h00;
    rx = 5'h00;
    interrupt_mask = 8'h05;
    controller_enable = 1'b1;
    arst_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (3) step();
    chk_flags(mailbox_ready_flag, 8'h00);
    timer_tick = 1'b1;
    repeat (5) step();
    timer_tick = 1'b0;
    chk_word(timer_value, 16'h0005);
    cfg(0, MOT_TX, 4'h5);
    cfg(1, MOT_TX, 4'h5);
    cfg(2, MOT_TX, 4'h5);
    cfg(3, MOT_TX, 4'h2);
    cfg(4, MOT_PRODUCER, 4'h1);
    cfg(5, MOT_CONSUMER, 4'h3);
    cfg(6, MOT_RX_OVW, 4'h0);
    chk_flags(mailbox_ready_flag, 8'h1f);
    step();
    chk_flags(mailbox_irq, 8'h05);
    // Three mailboxes commanded at once leave in rank, then number, order.
    glob(1'b0, 8'h0b);
    chk_flags(mailbox_ready_flag, 8'h14);
    wait_rdy(8'h0b);
    chk_flags(sent[0] & 8'h87, 8'h03);
    chk_flags(sent[1] & 8'h87, 8'h00);
    chk_flags(sent[2] & 8'h87, 8'h01);
    chk_word(mailbox_stamp_field[3], 16'h0005);
    sent.delete();
    // Aborts before the engine starts; an idle mailbox ignores the global abort.
    gap = 4'hf;
    cmd(1, 7'h48);
    cmd(1, 7'h20);
    cmd(0, 7'h42);
    glob(1'b1, 8'h05);
    chk_flags(abort_done_flag, 8'h03);
    chk_flags(mailbox_ready_flag & 8'h07, 8'h07);
    gap = 4'h0;
    cmd(3, 7'h41);
    wait_sent(1);
    cmd(3, 7'h20);
    wait_rdy(8'h08);
    chk_flags(abort_done_flag & 8'h08, 8'h00);
    // The aborted frame is still on the wire; let it end before the engine is told to lose.
    repeat (4) step();
    sent.delete();
    // A lost frame yields to a newer, better ranked request, then retries.
    lose = 1'b1;
    cmd(1, 7'h43);
    wait_sent(1);
    cmd(3, 7'h46);
    repeat (4) step();
    lose = 1'b0;
    chk_flags(mailbox_ready_flag & 8'h02, 8'h00);
    wait_rdy(8'h0a);
    chk_flags(sent[1], 8'h33);
    chk_flags(sent[2], 8'h19);
    sent.delete();
    mode.retry_disable = 1'b1;
    lose = 1'b1;
    cmd(2, 7'h48);
    wait_rdy(8'h04);
    chk_flags(abort_done_flag & 8'h04, 8'h04);
    chk_flags(8'(sent.size()), 8'h01);
    lose = 1'b0;
    mode.retry_disable = 1'b0;
    mode.stamp_at_frame_end = 1'b1;
    timer_tick = 1'b1;
    repeat (2) step();
    timer_tick = 1'b0;
    cmd(2, 7'h50);
    chk_flags(abort_done_flag & 8'h04, 8'h00);
    wait_rdy(8'h04);
    chk_flags(sent[1], 8'h82);
    chk_word(mailbox_stamp_field[2], 16'h0007);
    chk_word(captured_time, 16'h0007);
    sent.delete();
    // Producer: a request with nothing prepared is missed, then answered once armed.
    rxf(4, 1'b1);
    chk_flags(message_missed_flag, 8'h10);
    rd(4);
    chk_flags(message_missed_flag, 8'h00);
    cmd(4, 7'h44);
    repeat (8) step();
    chk_flags(8'(sent.size()), 8'h00);
    rxf(4, 1'b1);
    wait_rdy(8'h10);
    chk_flags(sent[0], 8'h24);
    sent.delete();
    // Consumer: remote request regardless of the control bit, first answer kept.
    cmd(5, 7'h42);
    wait_sent(1);
    repeat (8) step();
    chk_flags(mailbox_ready_flag & 8'h20, 8'h00);
    chk_flags(sent[0] & 8'h87, 8'h85);
    rxf(5, 1'b0);
    chk_flags(mailbox_ready_flag & 8'h20, 8'h20);
    chk_word(mailbox_stamp_field[5], 16'h0007);
    rxf(5, 1'b0);
    chk_flags(message_missed_flag & 8'h20, 8'h20);
    interrupt_mask = 8'hff;
    repeat (2) step();
    chk_flags(mailbox_irq, 8'h3f);
    tally_and_finish();
  end
endmodule : cmb_mailbox_top_test
